// ==== sled_top.sv ====
// Purpose: Front panel status indicator logic with AHB-Lite registers
// Assumes: Status inputs are asynchronous and pass two flip-flops
// Notes:   Colour outputs are 2-bit sled_color_t codes
// Overview
// The block watches a bundle of asynchronous status levels from the
// module and a small AHB-Lite register window. From them it derives
// four kinds of lamp: the bus access lamp, the activity lamp and one
// lamp per input and per output channel. Every lamp is a two bit
// colour code, off, amber, green or red, and each one is registered
// so that the panel never sees a combinational glitch.
//
// Status inputs
// All status levels come from other parts of the module and are not
// related to this clock. They pass a two stage synchroniser before any
// logic reads them. Only the second stage is read; the first stage is
// left alone so that a metastable value has a full cycle to settle.
// A level therefore reaches a lamp three cycles after it is sampled,
// and an error reaches a lamp four cycles after it is sampled, since
// it passes the error latch as well.
//
// Error handling
// Errors are sticky. Once an error source has been seen the matching
// latch stays set until software writes the clear register. A cause
// that is still present when the clear is written sets its latch
// again at once, so a live fault can never be hidden by a clear.
// Board errors turn the activity lamp and every channel lamp red. A streaming underflow turns only
// the lamp of its own channel red, together with the activity lamp.
// Red wins over every other display, including the alternating one
// shown while the timebase changes.
//
// Limitations
// The pulse and alternation spans are long counts of the module
// clock. They are fixed in the package and are not parameters.
// A lamp that is red for a board error cannot show channel detail;
// software must read the error register to find the cause.
//
// Register window (byte offsets, one word each)
//   0x00 Channel control, read and write
//        [1:0] input armed, [3:2] input running,
//        [5:4] output armed, [7:6] output running.
//        Running beats armed when both are set.
//   0x04 Latched errors, read only
//        [8:0] board error causes, [13:12] input underflow,
//        [15:14] output underflow.
//   0x08 Event status, a read clears it
//        bit 0 access, bit 1 error seen, bit 2 underflow.
//        An event in the cycle of the clearing read still sets.
//   0x0C Event mask, same layout as the event status.
//   0x10 Clear, write bit 0 as one to clear errors and control.
// Unmapped reads give zero; unmapped writes are ignored.
//
// Bus timing
// The slave never stretches a transfer: hreadyout is tied high and
// hresp is tied to OKAY. An address phase is taken when hsel, hready
// and a NONSEQ transfer type meet at a rising edge. Write data are
// taken in the following cycle. Read data are registered at the end
// of the address phase, so they stand through the data phase and
// hold until the next read. Back to back transfers are allowed.
//
// Interrupt
// The interrupt line is a level, high while any event status bit is
// set and unmasked. It is registered and so lags the status by one
// cycle.
//
// The AHB-Lite register port and the address map were decided locally.
`timescale 1ns/1ps
module sled_top (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic      [31:0]             hrdata,
  output logic                         hreadyout,
  output logic                         hresp,
  input  wire sled_pkg::sled_hw_t      hw_in,
  output logic                         irq,
  output sled_pkg::sled_color_t        access_led,
  output sled_pkg::sled_color_t        active_led,
  output sled_pkg::sled_color_t [1:0]  ai_led,
  output sled_pkg::sled_color_t [1:0]  ao_led
);
  localparam int N = sled_pkg::NCH;
  localparam int EW = sled_pkg::ERRW;

  // Synchroniser stages for hardware status
  sled_pkg::sled_hw_t  hw_s1_reg, hw_s2_reg;
  // Bus address phase capture
  logic                wr_pend_reg, wr_pend_next;
  logic                rd_pend_reg, rd_pend_next;
  logic [7:0]          addr_reg, addr_next;
  logic [31:0]         rdata_reg, rdata_next;
  // Control: [1:0] ai arm, [3:2] ai run, [5:4] ao arm, [7:6] ao run
  logic [4*N-1:0]      ctrl_reg, ctrl_next;
  // Latched board errors and per channel underflow
  logic [EW-1:0]       err_reg, err_next;
  logic [N-1:0]        ai_uf_reg, ai_uf_next;
  logic [N-1:0]        ao_uf_reg, ao_uf_next;
  // Events: bit0 access, bit1 any error cause including underflow, bit2 underflow
  logic [2:0]          stat_reg, stat_next;
  logic [2:0]          mask_reg, mask_next;
  // Access pulse and alternation timers
  logic [31:0]         pulse_reg, pulse_next;
  logic [31:0]         blink_reg, blink_next;
  logic                phase_reg, phase_next;
  // Registered outputs
  sled_pkg::sled_color_t        acc_next, act_next;
  sled_pkg::sled_color_t [1:0]  ai_next, ao_next;
  logic                         irq_next;

  // Board error source vector
  logic [EW-1:0] err_src;
  logic          access_ev, any_err, any_uf;
  logic          brd_err;  // Latched board error, underflow excluded

  // Shows one channel from its arm, run and error state
  function automatic sled_pkg::sled_color_t chan_color(
    input logic arm, input logic run, input logic err,
    input logic sw, input logic ph);
    if (err)      chan_color = sled_pkg::SLED_RED;
    else if (sw)  chan_color = ph ? sled_pkg::SLED_GREEN
                                  : sled_pkg::SLED_AMBER;
    else if (run) chan_color = sled_pkg::SLED_GREEN;
    else if (arm) chan_color = sled_pkg::SLED_AMBER;
    else          chan_color = sled_pkg::SLED_OFF;
  endfunction

  // Two stage synchroniser for status pins
  // The reset value of zero makes the PLL look unlocked for the first
  // cycles after reset; software clears that latch once the lock is
  // seen. Resetting to one instead would hide a real unlock at power up.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hw_s1_reg <= '0;
      hw_s2_reg <= '0;
    end else begin
      hw_s1_reg <= hw_in;
      hw_s2_reg <= hw_s1_reg;
    end
  end

  // Error sources from synchronised status
  always_comb begin
    err_src = '0;
    err_src[sled_pkg::E_TEMP]   = hw_s2_reg.over_temp;
    err_src[sled_pkg::E_SUPPLY] = hw_s2_reg.supply_bad;
    err_src[sled_pkg::E_PLL]    = ~hw_s2_reg.pll_lock;
    err_src[sled_pkg::E_CLK100] = hw_s2_reg.ext_tb
                                  & ~hw_s2_reg.clk100_ok;
    err_src[sled_pkg::E_OVOLT]  = hw_s2_reg.ovolt;
    err_src[sled_pkg::E_OCURR]  = hw_s2_reg.ocurr;
    err_src[sled_pkg::E_OVLD]   = hw_s2_reg.ovld;
    err_src[sled_pkg::E_UFLOW]  = |hw_s2_reg.ai_uflow
                                  | (|hw_s2_reg.ao_uflow);
    err_src[sled_pkg::E_HWFAIL] = hw_s2_reg.hw_fail;
  end

  // Bus, registers, errors, timers and indicators
  // All next state values are formed here and registered below.
  // Order of the sections matters where two of them touch the same
  // value: the software clear comes after the error accumulation so
  // that it wins over history but not over a live cause, and the
  // event sets come after the clearing read so that an event in the
  // cycle of the read is not lost.
  always_comb begin
    wr_pend_next = 1'b0;
    rd_pend_next = 1'b0;
    addr_next    = addr_reg;
    rdata_next   = rdata_reg;
    ctrl_next    = ctrl_reg;
    mask_next    = mask_reg;
    access_ev    = 1'b0;
    // Address phase
    if (hsel && hready && htrans == sled_pkg::HTRANS_NONSEQ) begin
      access_ev    = 1'b1;
      wr_pend_next = hwrite;
      rd_pend_next = ~hwrite;
      addr_next    = haddr[7:0];
    end
    // Error latches hold until a module reset
    err_next   = err_reg | err_src;
    ai_uf_next = ai_uf_reg | hw_s2_reg.ai_uflow;
    ao_uf_next = ao_uf_reg | hw_s2_reg.ao_uflow;
    any_err    = |err_src;
    any_uf     = |hw_s2_reg.ai_uflow | (|hw_s2_reg.ao_uflow);
    // Underflow stays per channel, so it is kept out of the board term
    brd_err    = |(err_reg & ~(EW'(1) << sled_pkg::E_UFLOW));
    stat_next  = stat_reg;
    // Write data phase
    if (wr_pend_reg) begin
      case (addr_reg)
        sled_pkg::OFS_CTRL:     ctrl_next = hwdata[4*N-1:0];
        sled_pkg::OFS_IRQ_MASK: mask_next = hwdata[2:0];
        sled_pkg::OFS_RESET: begin
          if (hwdata[0]) begin
            // Software module reset clears errors; live causes re-set
            err_next   = err_src;
            ai_uf_next = hw_s2_reg.ai_uflow;
            ao_uf_next = hw_s2_reg.ao_uflow;
            ctrl_next  = '0;
          end
        end
        default: ;
      endcase
    end
    // Read data, one cycle after address phase
    if (rd_pend_next) begin
      case (haddr[7:0])
        sled_pkg::OFS_CTRL:     rdata_next = 32'(ctrl_reg);
        sled_pkg::OFS_ERRS:     rdata_next = {16'h0000,
                                  2'(ao_uf_reg), 2'(ai_uf_reg),
                                  3'h0, err_reg};
        sled_pkg::OFS_IRQ_STAT: rdata_next = 32'(stat_reg);
        sled_pkg::OFS_IRQ_MASK: rdata_next = 32'(mask_reg);
        default:                rdata_next = 32'h00000000;
      endcase
      // Read of status clears it
      if (haddr[7:0] == sled_pkg::OFS_IRQ_STAT) stat_next = '0;
    end
    // Events set over the read clear
    if (access_ev) stat_next[0] = 1'b1;
    if (any_err)   stat_next[1] = 1'b1;
    if (any_uf)    stat_next[2] = 1'b1;
    irq_next = |(stat_reg & mask_reg);
    // Access pulse timer restarts on each access
    if (access_ev)           pulse_next = 32'(sled_pkg::PULSE_CYC);
    else if (pulse_reg != 0) pulse_next = pulse_reg - 32'd1;
    else                     pulse_next = pulse_reg;
    // Alternation timer
    if (blink_reg == 32'(sled_pkg::BLINK_CYC - 1)) begin
      blink_next = '0;
      phase_next = ~phase_reg;
    end else begin
      blink_next = blink_reg + 32'd1;
      phase_next = phase_reg;
    end
    // Access indicator
    if (!hw_s2_reg.ready || hw_s2_reg.rail_fault)
      acc_next = sled_pkg::SLED_OFF;
    else if (pulse_reg != 0)
      acc_next = sled_pkg::SLED_AMBER;
    else
      acc_next = sled_pkg::SLED_GREEN;
    // Activity indicator, red first
    if (|err_reg || |ai_uf_reg || |ao_uf_reg)
      act_next = sled_pkg::SLED_RED;
    else if (hw_s2_reg.tb_switch)
      act_next = phase_reg ? sled_pkg::SLED_GREEN
                           : sled_pkg::SLED_AMBER;
    else if (|ctrl_reg[2*N-1:N] || |ctrl_reg[4*N-1:3*N])
      act_next = sled_pkg::SLED_GREEN;
    else if (|ctrl_reg[N-1:0] || |ctrl_reg[3*N-1:2*N])
      act_next = sled_pkg::SLED_AMBER;
    else
      act_next = sled_pkg::SLED_OFF;
    // Channel indicators
    for (int i = 0; i < N; i++) begin
      ai_next[i] = chan_color(ctrl_reg[i], ctrl_reg[N+i],
                     brd_err | ai_uf_reg[i],
                     hw_s2_reg.tb_switch, phase_reg);
      ao_next[i] = chan_color(ctrl_reg[2*N+i], ctrl_reg[3*N+i],
                     brd_err | ao_uf_reg[i],
                     hw_s2_reg.tb_switch, phase_reg);
    end
  end

  // Register all state and outputs
  // Every lamp output and irq are taken straight from a flip-flop here, so the
  // lamps and the interrupt change only on the clock edge.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= '0;
      rdata_reg   <= '0;
      ctrl_reg    <= '0;
      err_reg     <= '0;
      ai_uf_reg   <= '0;
      ao_uf_reg   <= '0;
      stat_reg    <= '0;
      mask_reg    <= '0;
      pulse_reg   <= '0;
      blink_reg   <= '0;
      phase_reg   <= 1'b0;
      irq         <= 1'b0;
      access_led  <= sled_pkg::SLED_OFF;
      active_led  <= sled_pkg::SLED_OFF;
      ai_led      <= '{default: sled_pkg::SLED_OFF};
      ao_led      <= '{default: sled_pkg::SLED_OFF};
    end else begin
      wr_pend_reg <= wr_pend_next;
      rd_pend_reg <= rd_pend_next;
      addr_reg    <= addr_next;
      rdata_reg   <= rdata_next;
      ctrl_reg    <= ctrl_next;
      err_reg     <= err_next;
      ai_uf_reg   <= ai_uf_next;
      ao_uf_reg   <= ao_uf_next;
      stat_reg    <= stat_next;
      mask_reg    <= mask_next;
      pulse_reg   <= pulse_next;
      blink_reg   <= blink_next;
      phase_reg   <= phase_next;
      irq         <= irq_next;
      access_led  <= acc_next;
      active_led  <= act_next;
      ai_led      <= ai_next;
      ao_led      <= ao_next;
    end
  end

  // Zero wait state slave, always OKAY
  assign hrdata    = rdata_reg;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
endmodule

// ==== sled_pkg.sv ====
// Purpose: Shared constants and types for the status indicator logic
// Assumes: 50 MHz module clock, 32-bit AHB-Lite register bus
// Notes:   Two input and two output channels
package sled_pkg;
  localparam int          CLK_HZ        = 50_000_000; // Module clock rate
  localparam int          PULSE_MS      = 75;         // Access pulse length
  localparam int          PULSE_CYC     = CLK_HZ / 1000 * PULSE_MS;
  localparam int          BLINK_CYC     = 12_500_000; // Alternation half period
  localparam int          NCH           = 2;          // Channels per direction
  localparam logic [7:0]  OFS_CTRL      = 8'h00;      // Channel control
  localparam logic [7:0]  OFS_ERRS      = 8'h04;      // Latched errors, read
  localparam logic [7:0]  OFS_IRQ_STAT  = 8'h08;      // Sticky events
  localparam logic [7:0]  OFS_IRQ_MASK  = 8'h0C;      // Event mask
  localparam logic [7:0]  OFS_RESET     = 8'h10;      // Write 1: clear errors
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;       // Bus transfer type
  localparam int          ERRW          = 9;          // Error vector width
  // Indicator colours
  typedef enum logic [1:0] {
    SLED_OFF, SLED_AMBER, SLED_GREEN, SLED_RED
  } sled_color_t;
  // Error cause bits
  localparam int E_TEMP = 0;
  localparam int E_SUPPLY = 1;
  localparam int E_PLL = 2;
  localparam int E_CLK100 = 3;
  localparam int E_OVOLT = 4;
  localparam int E_OCURR = 5;
  localparam int E_OVLD = 6;
  localparam int E_UFLOW = 7;
  localparam int E_HWFAIL = 8;
  // Hardware status inputs grouped together
  typedef struct packed {
    logic            ready;      // Module functional and programmable
    logic            rail_fault; // Backplane rail problem
    logic            tb_switch;  // Timebase change in progress
    logic            ext_tb;     // External 100 MHz timebase selected
    logic            clk100_ok;  // Backplane 100 MHz clock present
    logic            pll_lock;   // PLL locked
    logic            over_temp;  // Board overheated
    logic            supply_bad; // Supply out of range
    logic            ovolt;      // External overvoltage
    logic            ocurr;      // External overcurrent
    logic            ovld;       // Overload
    logic            hw_fail;    // Internal failure
    logic [NCH-1:0]  ai_uflow;   // Input channel underflow
    logic [NCH-1:0]  ao_uflow;   // Output channel underflow
  } sled_hw_t;
endpackage

// ==== sled_props.sv ====
// Purpose: Port assertions for the status indicator block
// Assumes: One clock, rst asynchronous and active high
// Notes:   Status inputs reach lamps in 3 cycles, errors in 4
`timescale 1ns/1ps
module sled_props (
  input wire logic                        clk,
  input wire logic                        rst,
  input wire logic                        hsel,
  input wire logic [31:0]                 haddr,
  input wire logic [1:0]                  htrans,
  input wire logic                        hwrite,
  input wire logic                        hready,
  input wire sled_pkg::sled_hw_t          hw_in,
  input wire sled_pkg::sled_color_t       access_led,
  input wire sled_pkg::sled_color_t       active_led,
  input wire sled_pkg::sled_color_t [1:0] ai_led,
  input wire sled_pkg::sled_color_t [1:0] ao_led
);
  logic [3:0] quiet_reg;  // Cycles since a clear request, saturating
  logic [3:0] quiet_next; // Next value of quiet_reg
  wire taken = hsel && hready && htrans == sled_pkg::HTRANS_NONSEQ;
  wire rdy = hw_in.ready && !hw_in.rail_fault;
  wire brd = hw_in.over_temp || hw_in.supply_bad || hw_in.ovolt ||
             hw_in.ocurr || hw_in.ovld || hw_in.hw_fail;
  // Count up, restart on any write to the clear register
  always_comb begin
    quiet_next = (quiet_reg == 4'hF) ? quiet_reg : quiet_reg + 4'h1;
    if (taken && hwrite && haddr[7:0] == sled_pkg::OFS_RESET) begin
      quiet_next = 4'h0;
    end
  end
  // Register the counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      quiet_reg <= 4'h0;
    end else begin
      quiet_reg <= quiet_next;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_rdy4;
    rdy [*4];
  endsequence
  sequence s_idle3;
    (rdy && !taken) [*3];
  endsequence
  a_acc_dark: assert property ((!rdy) [*4] |-> access_led == 2'h0)
    else $error("access lamp lit while unready");
  a_pulse_start: assert property (s_rdy4 ##0 taken ##1 rdy [*3] |->
    access_led == sled_pkg::SLED_AMBER) else $error("no access pulse");
  a_acc_green: assert property (s_idle3 ##0 access_led ==
    sled_pkg::SLED_GREEN ##1 s_idle3 |-> access_led == sled_pkg::SLED_GREEN)
    else $error("idle access lamp not green");
  a_board_red: assert property (brd [*5] |-> active_led == 2'h3 &&
    ai_led[1] == 2'h3 && ao_led[0] == 2'h3) else $error("board error");
  a_pll_red: assert property ((!hw_in.pll_lock) [*5] |->
    active_led == 2'h3 && ao_led[1] == 2'h3) else $error("pll unlock");
  a_clk_gone: assert property ((hw_in.ext_tb && !hw_in.clk100_ok) [*5]
    |-> ai_led[0] == 2'h3) else $error("missing clock not red");
  a_uflow_red: assert property (hw_in.ai_uflow[1] [*5] |->
    ai_led[1] == 2'h3 && active_led == 2'h3) else $error("underflow");
  a_red_holds: assert property (active_led == 2'h3 && quiet_reg > 4'h6
    |=> active_led == 2'h3) else $error("error display dropped");
  a_alt_colours: assert property (hw_in.tb_switch [*4] ##0
    active_led != 2'h3 |-> active_led inside {2'h1, 2'h2} &&
    ai_led[0] inside {2'h1, 2'h2}) else $error("switch display wrong");
endmodule
bind sled_top sled_props u_props (.*);

// ==== sled_panel.sv ====
// Purpose: Operator view of the channel lamps
// Assumes: Colour codes of the package
// Notes:   Reports how many channel lamps show red
`timescale 1ns/1ps
module sled_panel (
  input  wire sled_pkg::sled_color_t [1:0] ai_led,  // Input channel lamps
  input  wire sled_pkg::sled_color_t [1:0] ao_led,  // Output channel lamps
  output logic [2:0]                       red_cnt  // Lamps now red
);
  // Tally the red lamps as the operator sees them
  always_comb begin
    red_cnt = 3'h0;
    for (int k = 0; k < 2; k++) begin
      red_cnt = red_cnt + 3'(ai_led[k] == sled_pkg::SLED_RED);
      red_cnt = red_cnt + 3'(ao_led[k] == sled_pkg::SLED_RED);
    end
  end
endmodule

// ==== sled_top_tb_top.sv ====
// Purpose: Self-checking bench for the status indicator block
// Assumes: 50 MHz clock, zero wait state bus
// Notes:   Pulse and blink spans outlast the run, only onsets are seen
`timescale 1ns/1ps
module sled_top_tb_top;
  logic                        clk = 1'b0;
  logic                        rst = 1'b1;
  logic                        hsel = 1'b0;
  logic [31:0]                 haddr = 32'h0;
  logic [1:0]                  htrans = 2'h0;
  logic                        hwrite = 1'b0;
  logic [31:0]                 hwdata = 32'h0;
  logic [31:0]                 hrdata, q;
  logic                        hreadyout, irq;
  sled_pkg::sled_hw_t          hw, cfg;
  sled_pkg::sled_color_t       bus_led, act_led;
  sled_pkg::sled_color_t [1:0] ai_led, ao_led;
  logic [2:0]                  red_cnt;
  int                          n_fail = 0;
  int                          checks_done = 0;
  // Control words and lamps {activity, input 0, output 0} they give
  logic [7:0]                  ctl [4] = '{8'h01, 8'h04, 8'h10, 8'h40};
  logic [5:0]                  want [4] = '{6'h14, 6'h28, 6'h11, 6'h22};
  always #10 clk = ~clk;
  sled_top DUT (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
    .hw_in(hw), .irq(irq), .access_led(bus_led), .active_led(act_led),
    .ai_led(ai_led), .ao_led(ao_led));
  sled_panel u_panel (.ai_led(ai_led), .ao_led(ao_led), .red_cnt(red_cnt));
  task automatic summarize;
    if (n_fail == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One single transfer; holds each phase until ready is seen
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= sled_pkg::HTRANS_NONSEQ;
    @(posedge clk);
    while (hreadyout !== 1'b1 && n++ < 40) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1 && n++ < 80) @(posedge clk);
    q = hrdata;
  endtask
  // Apply the status levels, then let them settle
  task automatic step(input int n);
    hw <= cfg;
    repeat (n) @(posedge clk);
  endtask
  // Raise or drop one error cause
  task automatic cause(input int i, input logic v);
    case (i)
      0: cfg.over_temp = v;
      1: cfg.supply_bad = v;
      2: cfg.pll_lock = !v;
      3: begin
        cfg.ext_tb = v;
        cfg.clk100_ok = !v;
      end
      4: cfg.ovolt = v;
      5: cfg.ocurr = v;
      6: cfg.ovld = v;
      7: cfg.ai_uflow[1] = v;
      default: cfg.hw_fail = v;
    endcase
  endtask
  // Watchdog against a hung bus or stuck sequence
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    summarize;
  end
  initial begin
    cfg = '0;
    cfg.ready = 1'b1;
    cfg.pll_lock = 1'b1;
    cfg.clk100_ok = 1'b1;
    hw = cfg;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    step(8);
    check(bus_led, sled_pkg::SLED_GREEN);
    bus(1'b1, sled_pkg::OFS_RESET, 32'h1);
    step(8);
    check(act_led, sled_pkg::SLED_OFF);
    cfg.ready = 1'b0;
    step(8);
    check(bus_led, sled_pkg::SLED_OFF);
    cfg.ready = 1'b1;
    cfg.rail_fault = 1'b1;
    step(8);
    check(bus_led, sled_pkg::SLED_OFF);
    cfg.rail_fault = 1'b0;
    step(8);
    bus(1'b0, 8'h20, 32'h0);
    check(q, 32'h0);
    step(2);
    check(bus_led, sled_pkg::SLED_AMBER);
    bus(1'b1, sled_pkg::OFS_IRQ_MASK, 32'h2);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, sled_pkg::OFS_CTRL, {24'h0, ctl[i]});
      step(6);
      check({act_led, ai_led[0], ao_led[0]}, want[i]);
    end
    cfg.tb_switch = 1'b1;
    step(8);
    check(act_led inside {2'h1, 2'h2}, 32'h1);
    check(ao_led[1] inside {2'h1, 2'h2}, 32'h1);
    cfg.tb_switch = 1'b0;
    for (int i = 0; i < 9; i++) begin
      cause(i, 1'b1);
      step(8);
      check(act_led, sled_pkg::SLED_RED);
      check(ai_led[1], sled_pkg::SLED_RED);
      check(red_cnt, (i == 7) ? 32'h1 : 32'h4);
      bus(1'b0, sled_pkg::OFS_ERRS, 32'h0);
      check(q[i], 32'h1);
      cause(i, 1'b0);
      step(8);
      check(act_led, sled_pkg::SLED_RED);
      check(irq, 32'h1);
      bus(1'b1, sled_pkg::OFS_RESET, 32'h1);
      step(8);
      check(act_led, sled_pkg::SLED_OFF);
      bus(1'b0, sled_pkg::OFS_IRQ_STAT, 32'h0);
      check(q[1], 32'h1);
      step(3);
      check(irq, 32'h0);
    end
    bus(1'b1, sled_pkg::OFS_IRQ_MASK, 32'h0);
    cause(0, 1'b1);
    step(8);
    check(irq, 32'h0);
    bus(1'b0, sled_pkg::OFS_IRQ_STAT, 32'h0);
    check(q[1], 32'h1);
    summarize;
  end
endmodule
